/* src/scgoc_top.sv */
// Clock gating and main oscillator control with register port and interrupt.
// Assumes a 40 MHz clock, a single-cycle strobe master and asynchronous active-low reset.
`timescale 1ns/1ps
`include "scgoc_map.svh"
module scgoc_top
  import scgoc_pkg::*;
#(
  parameter int          SLOW_DIV  = `SCGOC_SLOW_DIV,
  parameter logic [31:0] PC_IMPL   = `SCGOC_PC_IMPL
)
(
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic [`SCGOC_ADDR_W-1:0] addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [31:0]              rdata,
  output logic                          cpu_clock_on,
  output logic                          usb_port_clock_on,
  output logic      [`SCGOC_PROG_N-1:0] prog_clock_out_on,
  output logic      [31:0]              periph_clock_on,
  output logic                          osc_enable_out,
  output logic                          osc_bypass_out,
  output logic                          osc_stable_out,
  output logic                          irq
);
  logic        rst_meta_b;
  logic        rst_sync_b;
  logic        slow_tick;
  logic        osc_stable_flag;

  // System and peripheral gate state
  logic [31:0] sys_clock_state;
  logic [31:0] next_sys_clock_state;
  logic [31:0] periph_clock_state;
  logic [31:0] next_periph_clock_state;

  // Configuration registers
  logic [31:0] main_osc_control;
  logic [31:0] next_main_osc_control;
  logic [31:0] pll_config;
  logic [31:0] master_clock_select;
  logic [31:0] application_clock_select;
  logic [31:0] prog_clock_out0_config;
  logic [31:0] prog_clock_out1_config;
  logic [31:0] next_pll_config;
  logic [31:0] next_master_clock_select;
  logic [31:0] next_application_clock_select;
  logic [31:0] next_prog_clock_out0_config;
  logic [31:0] next_prog_clock_out1_config;

  // Interrupt state
  logic [31:0] event_status;
  logic [31:0] next_event_status;
  logic [31:0] irq_mask_state;
  logic [31:0] next_irq_mask_state;
  logic        next_irq;
  logic        stable_q;
  logic        freq_valid_q;
  logic [31:0] events;

  // Frequency measurement
  scgoc_meas_e                meas_state;
  scgoc_meas_e                next_meas_state;
  logic [3:0]                 meas_ticks;
  logic [3:0]                 next_meas_ticks;
  logic [`SCGOC_FREQ_W-1:0]   meas_cycles;
  logic [`SCGOC_FREQ_W-1:0]   next_meas_cycles;
  logic [`SCGOC_FREQ_W-1:0]   main_freq_count;
  logic [`SCGOC_FREQ_W-1:0]   next_main_freq_count;
  logic                       main_freq_valid;
  logic                       next_main_freq_valid;

  logic [31:0] next_rdata;
  logic        wr_sc_en;
  logic        wr_sc_dis;
  logic        wr_pc_en;
  logic        wr_pc_dis;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  scgoc_slow_tick #(
    .DIV (SLOW_DIV)
  ) u_slow_tick (
    .clock (clock),
    .rst_b (rst_sync_b),
    .tick  (slow_tick)
  );

  scgoc_osc_ctrl u_osc_ctrl (
    .clock             (clock),
    .rst_b             (rst_sync_b),
    .slow_tick         (slow_tick),
    .osc_enable        (main_osc_control[`SCGOC_OSC_EN_BIT]),
    .osc_bypass        (main_osc_control[`SCGOC_OSC_BYP_BIT]),
    .osc_startup_count (main_osc_control[`SCGOC_OSC_CNT_LSB +: `SCGOC_OSC_CNT_W]),
    .osc_stable_flag   (osc_stable_flag)
  );

  assign wr_sc_en  = wr && (addr == `SCGOC_SC_EN_OFF);
  assign wr_sc_dis = wr && (addr == `SCGOC_SC_DIS_OFF);
  assign wr_pc_en  = wr && (addr == `SCGOC_PC_EN_OFF);
  assign wr_pc_dis = wr && (addr == `SCGOC_PC_DIS_OFF);

  // Set-only and clear-only writes; zero bits leave gates alone
  always_comb
  begin
    next_sys_clock_state = sys_clock_state;
    if (wr_sc_en)
      next_sys_clock_state = sys_clock_state | (wdata & `SCGOC_SC_MASK);
    else if (wr_sc_dis)
      next_sys_clock_state = sys_clock_state & ~(wdata & `SCGOC_SC_MASK);
  end

  // Unimplemented identifiers are masked off and never stored
  always_comb
  begin
    next_periph_clock_state = periph_clock_state;
    if (wr_pc_en)
      next_periph_clock_state = periph_clock_state | (wdata & PC_IMPL);
    else if (wr_pc_dis)
      next_periph_clock_state = periph_clock_state & ~(wdata & PC_IMPL);
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      sys_clock_state    <= `SCGOC_SC_RST;
      periph_clock_state <= `SCGOC_PC_RST;
      cpu_clock_on       <= 1'b1;
      usb_port_clock_on  <= 1'b0;
      prog_clock_out_on  <= '0;
      periph_clock_on    <= '0;
    end
    else
    begin
      sys_clock_state    <= next_sys_clock_state;
      periph_clock_state <= next_periph_clock_state;
      cpu_clock_on       <= next_sys_clock_state[`SCGOC_CPU_BIT];
      usb_port_clock_on  <= next_sys_clock_state[`SCGOC_USB_BIT];
      prog_clock_out_on  <= next_sys_clock_state[`SCGOC_PROG_LSB +: `SCGOC_PROG_N];
      periph_clock_on    <= next_periph_clock_state;
    end
  end

  // Read/write configuration, oscillator control masked, interrupt mask set/clear; clock sources they name live elsewhere
  always_comb
  begin
    next_main_osc_control         = main_osc_control;
    next_pll_config               = pll_config;
    next_master_clock_select      = master_clock_select;
    next_application_clock_select = application_clock_select;
    next_prog_clock_out0_config   = prog_clock_out0_config;
    next_prog_clock_out1_config   = prog_clock_out1_config;
    next_irq_mask_state           = irq_mask_state;
    if (wr)
    begin
      unique case (addr)
        `SCGOC_OSC_CTL_OFF: next_main_osc_control = wdata & `SCGOC_OSC_MASK;
        `SCGOC_PLL_OFF:     next_pll_config = wdata;
        `SCGOC_MCK_OFF:     next_master_clock_select = wdata;
        `SCGOC_ACK_OFF:     next_application_clock_select = wdata;
        `SCGOC_PCK0_OFF:    next_prog_clock_out0_config = wdata;
        `SCGOC_PCK1_OFF:    next_prog_clock_out1_config = wdata;
        `SCGOC_IRQ_SET_OFF: next_irq_mask_state = irq_mask_state | (wdata & `SCGOC_EV_MASK);
        `SCGOC_IRQ_CLR_OFF: next_irq_mask_state = irq_mask_state & ~(wdata & `SCGOC_EV_MASK);
        default:            next_irq_mask_state = irq_mask_state;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      main_osc_control         <= `SCGOC_OSC_RST;
      pll_config               <= `SCGOC_PLL_RST;
      master_clock_select      <= `SCGOC_ZERO_RST;
      application_clock_select <= `SCGOC_ZERO_RST;
      prog_clock_out0_config   <= `SCGOC_ZERO_RST;
      prog_clock_out1_config   <= `SCGOC_ZERO_RST;
      irq_mask_state           <= `SCGOC_ZERO_RST;
      osc_enable_out           <= 1'b0;
      osc_bypass_out           <= 1'b0;
      osc_stable_out           <= 1'b0;
    end
    else
    begin
      main_osc_control         <= next_main_osc_control;
      pll_config               <= next_pll_config;
      master_clock_select      <= next_master_clock_select;
      application_clock_select <= next_application_clock_select;
      prog_clock_out0_config   <= next_prog_clock_out0_config;
      prog_clock_out1_config   <= next_prog_clock_out1_config;
      irq_mask_state           <= next_irq_mask_state;
      osc_enable_out           <= next_main_osc_control[`SCGOC_OSC_EN_BIT];
      osc_bypass_out           <= next_main_osc_control[`SCGOC_OSC_BYP_BIT];
      osc_stable_out           <= osc_stable_flag;
    end
  end

  // Count clock cycles across sixteen slow periods, aligned to a tick
  always_comb
  begin
    next_meas_state      = meas_state;
    next_meas_ticks      = meas_ticks;
    next_meas_cycles     = meas_cycles;
    next_main_freq_count = main_freq_count;
    next_main_freq_valid = main_freq_valid;
    unique case (meas_state)
      SCGOC_MEAS_IDLE:
        if (osc_stable_flag && slow_tick)
        begin
          next_meas_state  = SCGOC_MEAS_RUN;
          next_meas_ticks  = 4'h0;
          next_meas_cycles = '0;
        end
      SCGOC_MEAS_RUN:
        if (!osc_stable_flag)
          next_meas_state = SCGOC_MEAS_IDLE;
        else
        begin
          // Saturate rather than wrap on a very slow divider setting
          if (meas_cycles != '1)
            next_meas_cycles = meas_cycles + {{(`SCGOC_FREQ_W-1){1'b0}}, 1'b1};
          if (slow_tick)
          begin
            next_meas_ticks = meas_ticks + 4'h1;
            if (meas_ticks == `SCGOC_FREQ_WIN)
            begin
              next_meas_state      = SCGOC_MEAS_DONE;
              next_main_freq_count = next_meas_cycles;
              next_main_freq_valid = 1'b1;
            end
          end
        end
      SCGOC_MEAS_DONE:
        if (!osc_stable_flag)
        begin
          next_meas_state      = SCGOC_MEAS_IDLE;
          next_main_freq_valid = 1'b0;
        end
      default:
        next_meas_state = SCGOC_MEAS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      meas_state      <= SCGOC_MEAS_IDLE;
      meas_ticks      <= 4'h0;
      meas_cycles     <= '0;
      main_freq_count <= '0;
      main_freq_valid <= 1'b0;
    end
    else
    begin
      meas_state      <= next_meas_state;
      meas_ticks      <= next_meas_ticks;
      meas_cycles     <= next_meas_cycles;
      main_freq_count <= next_main_freq_count;
      main_freq_valid <= next_main_freq_valid;
    end
  end

  // Sticky events; a new event beats a same-cycle write-one clear
  always_comb
  begin
    events = '0;
    events[`SCGOC_EV_OSC_BIT]  = osc_stable_flag && !stable_q;
    events[`SCGOC_EV_FREQ_BIT] = main_freq_valid && !freq_valid_q;
    next_event_status = event_status;
    if (wr && (addr == `SCGOC_STATUS_OFF))
      next_event_status = event_status & ~wdata;
    next_event_status = (next_event_status | events) & `SCGOC_EV_MASK;
    next_irq = |(next_event_status & next_irq_mask_state);
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      event_status <= `SCGOC_ZERO_RST;
      stable_q     <= 1'b0;
      freq_valid_q <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      event_status <= next_event_status;
      stable_q     <= osc_stable_flag;
      freq_valid_q <= main_freq_valid;
      irq          <= next_irq;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb
  begin
    next_rdata = '0;
    if (rd)
    begin
      unique case (addr)
        `SCGOC_SC_STATE_OFF: next_rdata = sys_clock_state;
        `SCGOC_PC_STATE_OFF: next_rdata = periph_clock_state;
        `SCGOC_OSC_CTL_OFF:  next_rdata = main_osc_control;
        `SCGOC_FREQ_OFF:
        begin
          next_rdata[`SCGOC_FREQ_W-1:0]    = main_freq_count;
          next_rdata[`SCGOC_FREQ_VAL_BIT]  = main_freq_valid;
        end
        `SCGOC_PLL_OFF:      next_rdata = pll_config;
        `SCGOC_MCK_OFF:      next_rdata = master_clock_select;
        `SCGOC_ACK_OFF:      next_rdata = application_clock_select;
        `SCGOC_PCK0_OFF:     next_rdata = prog_clock_out0_config;
        `SCGOC_PCK1_OFF:     next_rdata = prog_clock_out1_config;
        `SCGOC_STATUS_OFF:
        begin
          next_rdata                     = event_status;
          next_rdata[`SCGOC_EV_OSC_BIT]  = osc_stable_flag;
          next_rdata[`SCGOC_MCK_RDY_BIT] = 1'b1;
        end
        `SCGOC_MASK_OFF:     next_rdata = irq_mask_state;
        default:             next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      rdata <= '0;
    else
      rdata <= next_rdata;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  cpu_enable_a: assert property (wr_sc_en && wdata[0] |=> cpu_clock_on)
    else $error("processor clock not started");
  cpu_disable_a: assert property (wr_sc_dis && wdata[0] |=> !cpu_clock_on
    ##1 (!cpu_clock_on || $past(wr_sc_en && wdata[0])))
    else $error("processor clock not stopped");
  usb_gate_a: assert property (wr_sc_en && wdata[7] && !wdata[0] |=> usb_port_clock_on
    && cpu_clock_on == $past(cpu_clock_on))
    else $error("usb clock gate wrong");
  prog_gate_a: assert property (wr_sc_dis && wdata[10:8] == 3'h7 |=> prog_clock_out_on == 3'h0)
    else $error("programmable outputs not stopped");
  prog_set_a: assert property (wr_sc_en |=> (prog_clock_out_on & $past(wdata[10:8]))
    == $past(wdata[10:8]))
    else $error("programmable outputs not started");
  periph_set_a: assert property (wr_pc_en |=> (periph_clock_on & $past(wdata) & PC_IMPL)
    == ($past(wdata) & PC_IMPL))
    else $error("peripheral clock not started");
  periph_clr_a: assert property (wr_pc_dis |=> (periph_clock_on & $past(wdata)) == 32'h0)
    else $error("peripheral clock not stopped");
  periph_impl_a: assert property (periph_clock_on[1:0] == 2'b00)
    else $error("unimplemented peripheral clock on");
  state_read_a: assert property (rd && addr == `SCGOC_SC_STATE_OFF |=> rdata[10:0]
    == {prog_clock_out_on, usb_port_clock_on, 6'h00, cpu_clock_on})
    else $error("system clock state read mismatch");
  wo_read_a: assert property (rd && (addr == `SCGOC_SC_EN_OFF
    || addr == `SCGOC_PC_DIS_OFF || addr == 8'h0C) |=> rdata == 32'h0)
    else $error("write-only read not zero");
  freq_win_a: assert property (meas_state == SCGOC_MEAS_RUN && meas_ticks == 4'hF
    && slow_tick && osc_stable_flag |=> main_freq_valid)
    else $error("frequency result not marked valid");
  irq_level_a: assert property (irq == |(event_status & irq_mask_state))
    else $error("interrupt level mismatch");
  irq_c: cover property (!irq ##1 irq);
  freq_c: cover property ($rose(main_freq_valid));
  gate_c: cover property (wr_pc_en ##1 wr_pc_dis);
endmodule

/* src/scgoc_map.svh */
// Register offsets, field positions, reset values and counts of the clock gating unit.
// Assumes a 40 MHz clock and a slow clock made as an enable pulse from a divider.
// Overview of operation
// - Enable write bit 0 starts processor clock
// - Disable write bit 0 stops processor clock
// - Bit 7 switches USB port clock
// - Enable bits 8..10 start programmable outputs
// - Disable bits 8..10 stop programmable outputs
// - State register mirrors running system clocks
// - System clock state resets to 0x01
// - Peripheral enable bits 2..31 start clocks
// - Peripheral disable bits stop clocks
// - Peripheral state shows running clocks, resets zero
// - Unimplemented peripheral bits change nothing
// - Oscillator enable; stable after start-up
// - Start-up wait is field times eight
// - Bypass sets stable flag at once
// - Clearing both bits clears stable flag
// - Frequency count over sixteen slow periods
`ifndef SCGOC_MAP_SVH
`define SCGOC_MAP_SVH

`define SCGOC_ADDR_W        8
`define SCGOC_SC_EN_OFF     8'h00
`define SCGOC_SC_DIS_OFF    8'h04
`define SCGOC_SC_STATE_OFF  8'h08
`define SCGOC_PC_EN_OFF     8'h10
`define SCGOC_PC_DIS_OFF    8'h14
`define SCGOC_PC_STATE_OFF  8'h18
`define SCGOC_OSC_CTL_OFF   8'h20
`define SCGOC_FREQ_OFF      8'h24
`define SCGOC_PLL_OFF       8'h2C
`define SCGOC_MCK_OFF       8'h30
`define SCGOC_ACK_OFF       8'h34
`define SCGOC_PCK0_OFF      8'h40
`define SCGOC_PCK1_OFF      8'h44
`define SCGOC_IRQ_SET_OFF   8'h60
`define SCGOC_IRQ_CLR_OFF   8'h64
`define SCGOC_STATUS_OFF    8'h68
`define SCGOC_MASK_OFF      8'h6C

`define SCGOC_CPU_BIT       0
`define SCGOC_USB_BIT       7
`define SCGOC_PROG_LSB      8
`define SCGOC_PROG_N        3
`define SCGOC_OSC_EN_BIT    0
`define SCGOC_OSC_BYP_BIT   1
`define SCGOC_OSC_CNT_LSB   8
`define SCGOC_OSC_CNT_W     8
`define SCGOC_OSC_MULT_SH   3
`define SCGOC_EV_OSC_BIT    0
`define SCGOC_MCK_RDY_BIT   3
`define SCGOC_EV_FREQ_BIT   16
`define SCGOC_EV_MASK       32'h00010001
`define SCGOC_FREQ_W        16
`define SCGOC_FREQ_VAL_BIT  16
`define SCGOC_FREQ_WIN      4'hF

`define SCGOC_SC_RST        32'h00000001
`define SCGOC_SC_MASK       32'h00000781
`define SCGOC_PC_RST        32'h00000000
`define SCGOC_PC_IMPL       32'hFFFFFFFC
`define SCGOC_OSC_RST       32'h00000000
`define SCGOC_OSC_MASK      32'h0000FF03
`define SCGOC_PLL_RST       32'h00003F00
`define SCGOC_ZERO_RST      32'h00000000
`define SCGOC_SLOW_DIV      1220

`endif

/* src/scgoc_pkg.sv */
// Types shared by the clock gating unit.
// Assumes nothing beyond the constant header.
package scgoc_pkg;
  typedef enum logic [1:0] {
    SCGOC_OSC_OFF    = 2'b00,
    SCGOC_OSC_WAIT   = 2'b01,
    SCGOC_OSC_READY  = 2'b10,
    SCGOC_OSC_BYPASS = 2'b11
  } scgoc_osc_e;
  typedef enum logic [1:0] {
    SCGOC_MEAS_IDLE = 2'b00,
    SCGOC_MEAS_RUN  = 2'b01,
    SCGOC_MEAS_DONE = 2'b10
  } scgoc_meas_e;
endpackage

/* src/scgoc_slow_tick.sv */
// Slow clock enable divider: one-cycle pulse every DIV clocks.
// Assumes a synchronised active-low reset.
`timescale 1ns/1ps
module scgoc_slow_tick
#(
  parameter int DIV = 1220
)
(
  input  wire logic clock,
  input  wire logic rst_b,
  output logic      tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_tick;

  always_comb
  begin
    next_tick = (cnt == 16'(DIV - 1));
    next_cnt  = next_tick ? 16'h0000 : cnt + 16'h0001;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

/* src/scgoc_osc_ctrl.sv */
// Main oscillator start-up sequencer and stable flag.
// Assumes slow_tick is a one-cycle enable and the control bits are registered.
`timescale 1ns/1ps
`include "scgoc_map.svh"
module scgoc_osc_ctrl
  import scgoc_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic                        slow_tick,
  input  wire logic                        osc_enable,
  input  wire logic                        osc_bypass,
  input  wire logic [`SCGOC_OSC_CNT_W-1:0] osc_startup_count,
  output logic                             osc_stable_flag
);
  scgoc_osc_e  state;
  scgoc_osc_e  next_state;
  logic [10:0] cnt;
  logic [10:0] next_cnt;
  logic [10:0] load_val;

  // Wait length in slow cycles is the field times eight
  assign load_val = {osc_startup_count, 3'b000};

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      SCGOC_OSC_OFF:
        if (osc_bypass)
          next_state = SCGOC_OSC_BYPASS;
        else if (osc_enable)
        begin
          next_state = SCGOC_OSC_WAIT;
          next_cnt   = load_val;
        end
      SCGOC_OSC_WAIT:
        if (osc_bypass)
          next_state = SCGOC_OSC_BYPASS;
        else if (!osc_enable)
          next_state = SCGOC_OSC_OFF;
        else if (slow_tick)
        begin
          if (cnt == 11'h000)
            next_state = SCGOC_OSC_READY;
          else
            next_cnt = cnt - 11'h001;
        end
      SCGOC_OSC_READY:
        if (osc_bypass)
          next_state = SCGOC_OSC_BYPASS;
        else if (!osc_enable)
          next_state = SCGOC_OSC_OFF;
      SCGOC_OSC_BYPASS:
        if (!osc_bypass)
        begin
          // Leaving bypass with the enable set starts a fresh wait
          next_state = osc_enable ? SCGOC_OSC_WAIT : SCGOC_OSC_OFF;
          next_cnt   = load_val;
        end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state           <= SCGOC_OSC_OFF;
      cnt             <= 11'h000;
      osc_stable_flag <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      cnt             <= next_cnt;
      osc_stable_flag <= (next_state == SCGOC_OSC_READY) || (next_state == SCGOC_OSC_BYPASS);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  bypass_sets_a: assert property (osc_bypass |=> osc_stable_flag)
    else $error("bypass did not raise stable flag");
  both_clear_a: assert property (!osc_enable && !osc_bypass |=> !osc_stable_flag)
    else $error("stable flag held with oscillator off");
  count_load_a: assert property (state == SCGOC_OSC_OFF && osc_enable && !osc_bypass
    |=> state == SCGOC_OSC_WAIT && cnt == {$past(osc_startup_count), 3'b000})
    else $error("start-up count not loaded");
  wait_done_a: assert property (state == SCGOC_OSC_WAIT && cnt == 11'h000 && slow_tick
    && osc_enable && !osc_bypass |=> osc_stable_flag)
    else $error("stable flag late after start-up");
  no_early_a: assert property ($rose(osc_stable_flag) && !$past(osc_bypass)
    |-> $past(state == SCGOC_OSC_WAIT && cnt == 11'h000 && slow_tick))
    else $error("stable flag without finished start-up");
  osc_ready_c: cover property (state == SCGOC_OSC_WAIT ##1 state == SCGOC_OSC_READY);
  osc_bypass_c: cover property (state == SCGOC_OSC_BYPASS);
endmodule

/* tb/test_system_clock_gating_and_osc_ctrl.sv */
// Self-checking bench for the clock gating unit: register port, gates, oscillator, irq.
// Assumes the design top scgoc_top with a shortened slow clock divider.
`timescale 1ns/1ps
`include "scgoc_map.svh"
module test_system_clock_gating_and_osc_ctrl;
  localparam int DIV = 4;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [31:0] rdata;
  logic        cpu_clock_on, usb_port_clock_on, osc_enable_out, osc_bypass_out;
  logic        osc_stable_out, irq;
  logic [2:0]  prog_clock_out_on;
  logic [31:0] periph_clock_on, v, sc, pc, rnd;
  logic [7:0]  ops [5] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h0C};
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          k;
  always #12.5 clock = ~clock;
  scgoc_top #(.SLOW_DIV(DIV)) dut_u (.clock(clock), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_clock_on(cpu_clock_on),
    .usb_port_clock_on(usb_port_clock_on), .prog_clock_out_on(prog_clock_out_on),
    .periph_clock_on(periph_clock_on), .osc_enable_out(osc_enable_out),
    .osc_bypass_out(osc_bypass_out), .osc_stable_out(osc_stable_out), .irq(irq));
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Expected pin images worked out from the bench copies of the state
  task automatic chk_gates();
    @(posedge clock);
    #1 chk("gates", {cpu_clock_on, usb_port_clock_on, prog_clock_out_on},
           {sc[0], sc[7], sc[10:8]});
    chk("periph", periph_clock_on, pc);
    rreg(8'h08, v);
    chk("sys_state", v, sc);
    rreg(8'h18, v);
    chk("periph_state", v, pc);
  endtask
  task automatic summarize();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end
  // Stable flag must not show before eight full slow periods per count unit
  task automatic osc_start(logic [7:0] cnt);
    wreg(8'h20, {16'h0000, cnt, 8'h01});
    repeat (cnt * 8 * DIV + 2) @(posedge clock);
    #1 chk("early_stable", osc_stable_out, 1'b0);
    chk("osc_pins", {osc_bypass_out, osc_enable_out}, 2'b01);
    k = 0;
    while (osc_stable_out !== 1'b1 && k < DIV)
    begin
      @(posedge clock);
      #1 k++;
    end
    chk("stable", osc_stable_out, 1'b1);
  endtask
  initial
  begin
    sc = 32'h00000001;
    pc = 32'h00000000;
    rnd = 32'd67;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    chk_gates();
    rreg(8'h68, v);
    chk("status_rst", v, 32'h00000008);
    rreg(8'h2C, v);
    chk("pll_rst", v, 32'h00003F00);
    for (int i = 0; i < 40; i++)
    begin
      rnd = xs(rnd);
      v = (i < 5) ? 32'hFFFFFFFF : xs(rnd);
      wreg(ops[rnd[31:28] % 5], v);
      case (ops[rnd[31:28] % 5])
        8'h00: sc = sc | (v & 32'h00000781);
        8'h04: sc = sc & ~(v & 32'h00000781);
        8'h10: pc = pc | (v & 32'hFFFFFFFC);
        8'h14: pc = pc & ~(v & 32'hFFFFFFFC);
        default: ;
      endcase
      chk_gates();
      rreg(ops[rnd[31:28] % 5], v);
      chk("wo_read", v, 32'h00000000);
    end
    $display("test gates done");
    wreg(8'h20, 32'h00000002);
    repeat (3) @(posedge clock);
    #1 chk("bypass_stable", osc_stable_out, 1'b1);
    chk("bypass_pins", {osc_bypass_out, osc_enable_out}, 2'b10);
    wreg(8'h60, 32'h00000001);
    @(posedge clock);
    #1 chk("irq_on", irq, 1'b1);
    wreg(8'h20, 32'h00000000);
    repeat (3) @(posedge clock);
    #1 chk("cleared_stable", osc_stable_out, 1'b0);
    chk("irq_sticky", irq, 1'b1);
    wreg(8'h68, 32'h00000001);
    @(posedge clock);
    #1 chk("irq_clear", irq, 1'b0);
    $display("test bypass irq done");
    osc_start(8'h00);
    wreg(8'h20, 32'h00000000);
    repeat (4) @(posedge clock);
    osc_start(8'h01);
    wreg(8'h20, 32'h00000000);
    repeat (4) @(posedge clock);
    osc_start(8'h02);
    repeat (20 * DIV) @(posedge clock);
    rreg(8'h24, v);
    chk("freq", v, 32'h00010000 | (16 * DIV));
    rreg(8'h20, v);
    chk("osc_ctl", v, 32'h00000201);
    $display("test startup done");
    summarize();
  end
endmodule
